//--- rtl/hec_map.svh
// constants for the host controller of an external 16-bit hamming corrector
// assumes 250 mhz i_clk, apb register access, corrector pins on plain ports
// Operation
// RULE1: corrector derives a 6-bit check word from each 16-bit data word
// RULE2: host stores check word beside data; reads hand corrector 22-bit word
// RULE3: single data-bit error is flagged; correction returns the fixed data word
// RULE4: single check-bit error: correction passes data unchanged, gives syndrome
// RULE5: any two-bit error in the 22-bit word is flagged, never corrected
// RULE6: all-zero or all-one stored words always report an error
// RULE7: host must not trust detection of three or more bit errors
// RULE8: flags valid only while strobed; host checks both low before using data
// RULE9: all six parity groups consistent means both flags low
// RULE10: check-bit and data-bit single errors flag alike; host corrects both
// RULE11: dual error flags mean uncorrectable; host raises an interrupt
// RULE12: each check bit comes from an eight-input parity generator on writes
// RULE13: on reads stored check word and data enter the parity checkers
// RULE14: check bits zero and one use inverted parity sense
// RULE15: each check bit is parity of a fixed data-bit subset
// RULE16: single error: single flag only; double error: both flags high
// RULE17: correction finds the bad bit by comparing check words, inverts it
// RULE18: while corrected data is driven, check port carries the syndrome
// RULE19: two select inputs pick generate, flag or correct and port direction
`ifndef HEC_MAP_SVH
`define HEC_MAP_SVH

`define HEC_DATA_W 16
`define HEC_CHECK_W 6
`define HEC_WORD_W 22

// select encodings {operation_select_high, operation_select_low}
`define HEC_SEL_GEN 2'b00
`define HEC_SEL_READ 2'b01
`define HEC_SEL_FLAG 2'b10
`define HEC_SEL_CORR 2'b11

// register byte offsets
`define HEC_REG_CTRL 8'h00
`define HEC_REG_ADDR 8'h04
`define HEC_REG_WDATA 8'h08
`define HEC_REG_RDATA 8'h0c
`define HEC_REG_SYND 8'h10
`define HEC_REG_STAT 8'h14
`define HEC_REG_IRQ_STAT 8'h18
`define HEC_REG_IRQ_MASK 8'h1c

// ctrl fields
`define HEC_CTRL_START 0
`define HEC_CTRL_READ 1

// irq fields (status and mask share the layout)
`define HEC_IRQ_DONE 0
`define HEC_IRQ_FIXED 1
`define HEC_IRQ_DUAL 2
`define HEC_IRQ_W 3

// stat fields
`define HEC_STAT_BUSY 0
`define HEC_STAT_SINGLE 1
`define HEC_STAT_DUAL 2
`define HEC_STAT_OK 3

// timing, ns at the corrector pins, and the clock period
`define HEC_CLK_NS 4
`define HEC_T_GEN_NS 25
`define HEC_T_FLAG_NS 16
`define HEC_T_OE_NS 15
`define HEC_SYNC_CYC 3

`endif

//--- rtl/hec_pkg.sv
// types shared by the corrector host controller
// assumes hec_map.svh sits in the include path
`include "hec_map.svh"

package hec_pkg;

   typedef logic [`HEC_DATA_W-1:0] hec_data_t;
   typedef logic [`HEC_CHECK_W-1:0] hec_check_t;

   // pins driven toward the corrector
   typedef struct packed {
      logic operation_select_high;
      logic operation_select_low;
      hec_data_t data_word_port;
      logic data_oe;
      hec_check_t check_word_port;
      logic check_oe;
   } hec_pin_out_s;

   // pins sampled from the corrector
   typedef struct packed {
      hec_data_t data_word_port;
      hec_check_t check_word_port;
      logic single_error_flag;
      logic dual_error_flag;
   } hec_pin_in_s;

   typedef enum logic [2:0] {
      HEC_IDLE,
      HEC_GEN,
      HEC_FETCH,
      HEC_FLAG,
      HEC_CORR
   } hec_state_e;

endpackage

//--- rtl/hec_sync.sv
// three-stage synchroniser for pins from the corrector
// assumes inputs are asynchronous to i_clk
`timescale 1ns/1ps

module hec_sync #(
   parameter int W = 24
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] ff1_q, ff2_q, ff3_q, out_q;
   logic [W-1:0] out_d;

   // a bit only moves once stages two and three agree, which masks settling glitches
   always_comb begin
      out_d = out_q;
      for (int i = 0; i < W; i++) begin
         if (ff2_q[i] == ff3_q[i]) begin
            out_d[i] = ff3_q[i];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         ff1_q <= '0;
         ff2_q <= '0;
         ff3_q <= '0;
         out_q <= '0;
      end else begin
         ff1_q <= i_async;
         ff2_q <= ff1_q;
         ff3_q <= ff2_q;
         out_q <= out_d;
      end
   end

   assign o_sync = out_q;
endmodule

//--- rtl/hec_mem.sv
// small memory array holding data words with their check words
// read data come from a register, one cycle after the address
`timescale 1ns/1ps

module hec_mem #(
   parameter int W = 22,
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   input wire logic i_clk,
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [W-1:0] i_wdata,
   input wire logic [AW-1:0] i_raddr,
   output logic [W-1:0] o_rdata
);
   logic [W-1:0] mem_q [DEPTH];
   logic [W-1:0] rdata_q;

   // no reset: contents are undefined until written, as with a real array
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem_q[i_waddr] <= i_wdata;
      end
      rdata_q <= mem_q[i_raddr];
   end

   assign o_rdata = rdata_q;
endmodule

//--- rtl/hec_ctrl.sv
// host controller for an external parallel hamming corrector
// apb slave for software; drives the corrector select and port pins,
// stores 22-bit words in a local array, reports flags and syndrome
`timescale 1ns/1ps
`include "hec_map.svh"

module hec_ctrl #(
   parameter int AW = 8,
   parameter int DEPTH = 256
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire hec_pkg::hec_pin_in_s i_pins,
   output hec_pkg::hec_pin_out_s o_pins,
   output logic o_irq
);
   import hec_pkg::*;

   function automatic logic [7:0] ns_to_cyc(input int ns);
      int c;
      c = (ns + `HEC_CLK_NS - 1) / `HEC_CLK_NS;
      if (c < 1) begin
         c = 1;
      end
      return c[7:0];
   endfunction

   localparam logic [7:0] GEN_CYC = ns_to_cyc(`HEC_T_GEN_NS) + 8'(`HEC_SYNC_CYC);
   localparam logic [7:0] FLAG_CYC = ns_to_cyc(`HEC_T_FLAG_NS + `HEC_T_OE_NS)
      + 8'(`HEC_SYNC_CYC);
   localparam logic [7:0] CORR_CYC = ns_to_cyc(`HEC_T_OE_NS + `HEC_T_GEN_NS)
      + 8'(`HEC_SYNC_CYC);

   hec_pin_in_s pin_s;
   logic [`HEC_WORD_W-1:0] mem_rdata;
   logic mem_we;

   hec_sync #(.W($bits(hec_pin_in_s))) u_sync (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_async(i_pins),
      .o_sync(pin_s)
   );

   // apb register state
   logic [AW-1:0] addr_q, addr_d;
   hec_data_t wdata_q, wdata_d;
   hec_data_t rdata_q, rdata_d;
   hec_check_t synd_q, synd_d;
   hec_check_t chk_q, chk_d;
   logic [`HEC_IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d;
   logic serr_q, serr_d, derr_q, derr_d, ok_q, ok_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;

   // sequencer state
   hec_state_e st_q, st_d;
   logic [7:0] cnt_q, cnt_d;
   logic op_read_q, op_read_d;
   hec_pin_out_s pins_q, pins_d;
   logic [`HEC_IRQ_W-1:0] ev;

   logic setup, wr, start;
   assign setup = i_psel && !i_penable;
   assign wr = setup && i_pwrite;
   assign start = wr && (i_paddr == `HEC_REG_CTRL) && i_pwdata[`HEC_CTRL_START]
      && (st_q == HEC_IDLE);

   hec_mem #(.W(`HEC_WORD_W), .DEPTH(DEPTH), .AW(AW)) u_mem (
      .i_clk(i_clk),
      .i_we(mem_we),
      .i_waddr(addr_q),
      .i_wdata({chk_d, wdata_q}),
      .i_raddr(addr_q),
      .o_rdata(mem_rdata)
   );

   // sequencer
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      op_read_d = op_read_q;
      pins_d = pins_q;
      rdata_d = rdata_q;
      synd_d = synd_q;
      chk_d = chk_q;
      serr_d = serr_q;
      derr_d = derr_q;
      ok_d = ok_q;
      mem_we = 1'b0;
      ev = '0;
      case (st_q)
         HEC_IDLE: begin
            if (start) begin
               op_read_d = i_pwdata[`HEC_CTRL_READ];
               ok_d = 1'b0;
               if (i_pwdata[`HEC_CTRL_READ]) begin
                  st_d = HEC_FETCH;
               end else begin
                  // corrector computes the check word from driven data [RULE1] [RULE12]
                  {pins_d.operation_select_high, pins_d.operation_select_low} =
                     `HEC_SEL_GEN; // [RULE19]
                  pins_d.data_word_port = wdata_q;
                  pins_d.data_oe = 1'b1;
                  pins_d.check_oe = 1'b0;
                  cnt_d = GEN_CYC;
                  st_d = HEC_GEN;
               end
            end
         end
         HEC_GEN: begin
            cnt_d = cnt_q - 8'h01;
            if (cnt_q == 8'h00) begin
               // store the check word beside its data word [RULE2]
               chk_d = pin_s.check_word_port;
               mem_we = 1'b1;
               pins_d.data_oe = 1'b0;
               {pins_d.operation_select_high, pins_d.operation_select_low} =
                  `HEC_SEL_READ;
               ev[`HEC_IRQ_DONE] = 1'b1;
               st_d = HEC_IDLE;
            end
         end
         HEC_FETCH: begin
            // hand the whole 22-bit stored word to the checkers [RULE2] [RULE13]
            pins_d.data_word_port = mem_rdata[`HEC_DATA_W-1:0];
            pins_d.check_word_port = mem_rdata[`HEC_WORD_W-1:`HEC_DATA_W];
            pins_d.data_oe = 1'b1;
            pins_d.check_oe = 1'b1;
            // strobe the flags on while the word is presented [RULE8]
            {pins_d.operation_select_high, pins_d.operation_select_low} =
               `HEC_SEL_FLAG; // [RULE19]
            cnt_d = FLAG_CYC;
            st_d = HEC_FLAG;
         end
         HEC_FLAG: begin
            cnt_d = cnt_q - 8'h01;
            if (cnt_q == 8'h00) begin
               serr_d = pin_s.single_error_flag;
               derr_d = pin_s.dual_error_flag;
               rdata_d = pins_q.data_word_port;
               synd_d = '0;
               if (!pin_s.single_error_flag && !pin_s.dual_error_flag) begin
                  // both low: data usable as read [RULE8] [RULE9]
                  ok_d = 1'b1;
                  pins_d.data_oe = 1'b0;
                  pins_d.check_oe = 1'b0;
                  {pins_d.operation_select_high, pins_d.operation_select_low} =
                     `HEC_SEL_READ;
                  ev[`HEC_IRQ_DONE] = 1'b1;
                  st_d = HEC_IDLE;
               end else if (pin_s.dual_error_flag) begin
                  // uncorrectable: no correction attempt, interrupt instead [RULE5] [RULE11]
                  // flags are taken at face value; triple errors may pass unseen [RULE7]
                  pins_d.data_oe = 1'b0;
                  pins_d.check_oe = 1'b0;
                  {pins_d.operation_select_high, pins_d.operation_select_low} =
                     `HEC_SEL_READ;
                  ev[`HEC_IRQ_DUAL] = 1'b1;
                  ev[`HEC_IRQ_DONE] = 1'b1;
                  st_d = HEC_IDLE;
               end else begin
                  // single flag only: correct whether data or check bit failed [RULE10]
                  // release both ports so the corrector can drive them [RULE19]
                  pins_d.data_oe = 1'b0;
                  pins_d.check_oe = 1'b0;
                  {pins_d.operation_select_high, pins_d.operation_select_low} =
                     `HEC_SEL_CORR;
                  cnt_d = CORR_CYC;
                  st_d = HEC_CORR;
               end
            end
         end
         HEC_CORR: begin
            cnt_d = cnt_q - 8'h01;
            if (cnt_q == 8'h00) begin
               // corrected data on the data port, syndrome on the check port
               rdata_d = pin_s.data_word_port; // [RULE3] [RULE4] [RULE17]
               synd_d = pin_s.check_word_port; // [RULE18]
               ok_d = 1'b1;
               {pins_d.operation_select_high, pins_d.operation_select_low} =
                  `HEC_SEL_READ;
               ev[`HEC_IRQ_FIXED] = 1'b1;
               ev[`HEC_IRQ_DONE] = 1'b1;
               st_d = HEC_IDLE;
            end
         end
         default: begin
            st_d = HEC_IDLE;
         end
      endcase
   end

   // apb slave, answers in the first access cycle
   always_comb begin
      addr_d = addr_q;
      wdata_d = wdata_q;
      imask_d = imask_q;
      ist_d = ist_q;
      prdata_d = prdata_q;
      pready_d = setup;
      pslverr_d = 1'b0;
      if (wr) begin
         case (i_paddr)
            `HEC_REG_CTRL: ;
            `HEC_REG_ADDR: addr_d = i_pwdata[AW-1:0];
            `HEC_REG_WDATA: wdata_d = i_pwdata[`HEC_DATA_W-1:0];
            `HEC_REG_IRQ_STAT: ist_d = ist_q & ~i_pwdata[`HEC_IRQ_W-1:0];
            `HEC_REG_IRQ_MASK: imask_d = i_pwdata[`HEC_IRQ_W-1:0];
            `HEC_REG_RDATA, `HEC_REG_SYND, `HEC_REG_STAT: ;
            default: pslverr_d = 1'b1;
         endcase
      end else if (setup) begin
         prdata_d = '0;
         case (i_paddr)
            `HEC_REG_CTRL: prdata_d[`HEC_CTRL_READ] = op_read_q;
            `HEC_REG_ADDR: prdata_d[AW-1:0] = addr_q;
            `HEC_REG_WDATA: prdata_d[`HEC_DATA_W-1:0] = wdata_q;
            `HEC_REG_RDATA: prdata_d[`HEC_DATA_W-1:0] = rdata_q;
            `HEC_REG_SYND: prdata_d[`HEC_CHECK_W-1:0] = synd_q;
            `HEC_REG_STAT: begin
               prdata_d[`HEC_STAT_BUSY] = (st_q != HEC_IDLE);
               prdata_d[`HEC_STAT_SINGLE] = serr_q;
               prdata_d[`HEC_STAT_DUAL] = derr_q;
               prdata_d[`HEC_STAT_OK] = ok_q;
            end
            `HEC_REG_IRQ_STAT: prdata_d[`HEC_IRQ_W-1:0] = ist_q;
            `HEC_REG_IRQ_MASK: prdata_d[`HEC_IRQ_W-1:0] = imask_q;
            default: pslverr_d = 1'b1;
         endcase
      end
      // a new event beats a clear in the same cycle
      ist_d = ist_d | ev;
      irq_d = |(ist_d & imask_d);
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         st_q <= HEC_IDLE;
         cnt_q <= 8'h00;
         op_read_q <= 1'b0;
         pins_q <= '{operation_select_high: 1'b0, operation_select_low: 1'b1,
                     default: '0};
         addr_q <= '0;
         wdata_q <= '0;
         rdata_q <= '0;
         synd_q <= '0;
         chk_q <= '0;
         serr_q <= 1'b0;
         derr_q <= 1'b0;
         ok_q <= 1'b0;
         ist_q <= '0;
         imask_q <= '0;
         prdata_q <= '0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         op_read_q <= op_read_d;
         pins_q <= pins_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         synd_q <= synd_d;
         chk_q <= chk_d;
         serr_q <= serr_d;
         derr_q <= derr_d;
         ok_q <= ok_d;
         ist_q <= ist_d;
         imask_q <= imask_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         irq_q <= irq_d;
      end
   end

   assign o_pins = pins_q;
   assign o_prdata = prdata_q;
   assign o_pready = pready_q;
   assign o_pslverr = pslverr_q;
   assign o_irq = irq_q;
endmodule

//--- sim/hec_dev_model.sv
// behavioural model of the parallel hamming corrector seen through its pins
// assumes host pins from hec_ctrl; i_err models stored-word faults
`timescale 1ns/1ps
`include "hec_map.svh"

module hec_dev_model (
   input wire hec_pkg::hec_pin_out_s i_pins,
   input wire logic [21:0] i_err,
   output hec_pkg::hec_pin_in_s o_pins
);
   import hec_pkg::*;
   localparam logic [15:0] MAT [6] = '{16'h271b, 16'h496d, 16'h92b6, 16'h1cc7, 16'he0f8,
      16'hff00};
   logic [1:0] sel;
   hec_data_t held_d;
   hec_check_t held_c;
   hec_check_t diff;
   hec_data_t fixed;

   function automatic hec_check_t gen(input hec_data_t d);
      hec_check_t g;
      for (int j = 0; j < 6; j++) begin
         g[j] = ^(d & MAT[j]);
      end
      return g ^ 6'h03;
   endfunction

   assign sel = {i_pins.operation_select_high, i_pins.operation_select_low};

   // correction works on the word captured while the flags were strobed
   always_latch begin
      if (sel == `HEC_SEL_FLAG) begin
         held_d <= i_pins.data_word_port;
         held_c <= i_pins.check_word_port;
      end
   end

   always_comb begin
      diff = gen(held_d) ^ held_c;
      fixed = held_d;
      for (int i = 0; i < 16; i++) begin
         if (diff == (gen(16'h1 << i) ^ gen(16'h0))) begin
            fixed[i] = ~held_d[i];
         end
      end
      // undriven ports show the inverse so a stale value never looks right
      o_pins.data_word_port = ~i_pins.data_word_port;
      o_pins.check_word_port = ~i_pins.check_word_port;
      o_pins.single_error_flag = 1'b1;
      o_pins.dual_error_flag = 1'b1;
      if (sel == `HEC_SEL_GEN) begin
         o_pins.check_word_port = gen(i_pins.data_word_port ^ i_err[15:0]) ^
            i_err[21:16];
      end
      if (sel == `HEC_SEL_FLAG || sel == `HEC_SEL_CORR) begin
         o_pins.single_error_flag = (diff != 6'h00);
         o_pins.dual_error_flag = (diff != 6'h00) && !(^diff);
      end
      if (sel == `HEC_SEL_CORR) begin
         o_pins.data_word_port = fixed;
         o_pins.check_word_port = ~diff;
      end
   end
endmodule

//--- sim/hec_ctrl_asserts.sv
// port assertions for the corrector host controller
// assumes the hec_ctrl ports and the select codes of hec_map.svh
`timescale 1ns/1ps
`include "hec_map.svh"

module hec_ctrl_asserts (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire hec_pkg::hec_pin_in_s i_pins,
   input wire hec_pkg::hec_pin_out_s o_pins,
   input wire logic o_irq
);
   import hec_pkg::*;
   logic [1:0] sel;
   logic sf;
   logic df;
   logic doe;
   logic coe;
   assign sel = {o_pins.operation_select_high, o_pins.operation_select_low};
   assign sf = i_pins.single_error_flag;
   assign df = i_pins.dual_error_flag;
   assign doe = o_pins.data_oe;
   assign coe = o_pins.check_oe;
   default clocking tick @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
      else $error("pready missing after setup");
   a_ready_one_cycle: assert property (o_pready |=> !o_pready)
      else $error("pready held too long");
   a_slverr_with_ready: assert property (o_pslverr |-> o_pready)
      else $error("pslverr without pready");
   a_gen_hold: assert property ($rose(sel == `HEC_SEL_GEN) |->
      (sel == `HEC_SEL_GEN && doe && !coe) [*8]) else $error("generate phase broken");
   a_flag_strobe: assert property ($rose(sel == `HEC_SEL_FLAG) |->
      (doe && coe && sel == `HEC_SEL_FLAG) [*8]) else $error("flag strobe broken");
   a_single_corrects: assert property ($fell(sel == `HEC_SEL_FLAG) && $past(sf) &&
      !$past(df) |-> sel == `HEC_SEL_CORR) else $error("single error not corrected");
   a_corr_cause: assert property ($fell(sel == `HEC_SEL_FLAG) && sel == `HEC_SEL_CORR
      |-> $past(sf) && !$past(df)) else $error("correction without single flag");
   a_dual_no_fix: assert property ($fell(sel == `HEC_SEL_FLAG) && $past(df) |->
      sel == `HEC_SEL_READ) else $error("dual error sent to correction");
   a_corr_release: assert property ($rose(sel == `HEC_SEL_CORR) |->
      (!doe && !coe) [*8]) else $error("ports driven during correction");

   cover property ($fell(sel == `HEC_SEL_FLAG) && sel == `HEC_SEL_CORR);
   cover property ($fell(sel == `HEC_SEL_FLAG) && sel == `HEC_SEL_READ);
   cover property (o_pslverr);
   cover property ($rose(o_irq));
endmodule

bind hec_ctrl hec_ctrl_asserts i_hec_ctrl_asserts (.i_clk(i_clk), .i_nrst(i_nrst),
   .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .i_pins(i_pins), .o_pins(o_pins), .o_irq(o_irq));

//--- sim/tb_top.sv
// self-checking bench for hec_ctrl against the corrector model
// assumes zero-wait apb slave and done polling through the irq status
`timescale 1ns/1ps
`include "hec_map.svh"

module tb_top;
   import hec_pkg::*;
   localparam logic [15:0] MAT [6] = '{16'h271b, 16'h496d, 16'h92b6, 16'h1cc7, 16'he0f8,
      16'hff00};
   logic i_clk, i_nrst, psel, penable, pwrite, pready, pslverr, irq, last_err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [21:0] err;
   hec_pin_in_s pins_in;
   hec_pin_out_s pins_out;
   int errors, checks_done;

   hec_ctrl i_hec_ctrl (.i_clk(i_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_pins(pins_in), .o_pins(pins_out), .o_irq(irq));
   hec_dev_model i_hec_dev_model (.i_pins(pins_out), .i_err(err), .o_pins(pins_in));

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   task finish_test;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge i_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      n = 0;
      // wait for the answer however long it takes; only the watchdog ends a hang
      do begin
         @(posedge i_clk);
         n++;
      end while (pready !== 1'b1);
      // the slave promises its answer in the first access cycle
      chk(n, 32'h1);
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask

   task rd(input logic [7:0] a, output logic [31:0] r);
      apb(1'b0, a, 32'h0, r);
   endtask

   task irq_is(input logic e);
      repeat (2) @(posedge i_clk);
      chk({31'h0, irq}, {31'h0, e});
   endtask

   // a second start while busy must leave the running operation alone
   task run(input logic [31:0] ctrl, input logic again);
      logic [31:0] r;
      int n;
      wr(`HEC_REG_IRQ_STAT, 32'h7);
      wr(`HEC_REG_CTRL, ctrl);
      if (again) wr(`HEC_REG_CTRL, 32'h3);
      n = 0;
      r = 32'h0;
      while (r[`HEC_IRQ_DONE] !== 1'b1 && n < 40) begin
         rd(`HEC_REG_IRQ_STAT, r);
         n++;
      end
      chk({31'h0, r[`HEC_IRQ_DONE]}, 32'h1);
   endtask

   task put(input logic [7:0] a, input logic [15:0] d, input logic [21:0] e, input logic again);
      wr(`HEC_REG_ADDR, {24'h0, a});
      wr(`HEC_REG_WDATA, {16'h0, d});
      err <= e;
      run(32'h1, again);
      err <= 22'h0;
   endtask

   task get(input logic [7:0] a, input logic [31:0] st, input logic [15:0] d,
      input logic [5:0] s, input logic [31:0] ir);
      logic [31:0] r;
      wr(`HEC_REG_ADDR, {24'h0, a});
      run(32'h3, 1'b0);
      rd(`HEC_REG_STAT, r);
      chk(r, st);
      rd(`HEC_REG_RDATA, r);
      chk(r, {16'h0, d});
      rd(`HEC_REG_SYND, r);
      chk(r, {26'h0, s});
      rd(`HEC_REG_IRQ_STAT, r);
      chk(r, ir);
   endtask

   function automatic logic [5:0] col(input int i);
      for (int j = 0; j < 6; j++) col[j] = MAT[j][i];
   endfunction

   task t_reset;
      logic [31:0] r;
      chk({28'h0, pins_out.operation_select_high, pins_out.operation_select_low,
         pins_out.data_oe, pins_out.check_oe}, 32'h4);
      irq_is(1'b0);
      rd(`HEC_REG_STAT, r);
      chk(r, 32'h0);
      rd(`HEC_REG_SYND, r);
      chk(r, 32'h0);
      rd(`HEC_REG_IRQ_STAT, r);
      chk(r, 32'h0);
      rd(8'h20, r);
      chk({31'h0, last_err}, 32'h1);
      $display("test reset done");
   endtask

   task t_clean;
      put(8'h01, 16'ha5c3, 22'h0, 1'b0);
      put(8'hff, 16'h5a3c, 22'h0, 1'b1);
      get(8'h01, 32'h8, 16'ha5c3, 6'h0, 32'h1);
      get(8'hff, 32'h8, 16'h5a3c, 6'h0, 32'h1);
      $display("test clean done");
   endtask

   // triple faults are left out on purpose: nothing is promised for them
   task t_dual;
      logic [21:0] pat [3] = '{22'h000003, 22'h210000, 22'h040008};
      wr(`HEC_REG_IRQ_MASK, 32'h4);
      for (int k = 0; k < 3; k++) begin
         put(8'h30, 16'h0ff0, pat[k], 1'b0);
         get(8'h30, 32'h6, 16'h0ff0, 6'h0, 32'h5);
      end
      irq_is(1'b1);
      wr(`HEC_REG_IRQ_MASK, 32'h0);
      irq_is(1'b0);
      wr(`HEC_REG_IRQ_MASK, 32'h4);
      irq_is(1'b1);
      wr(`HEC_REG_IRQ_STAT, 32'h4);
      irq_is(1'b0);
      $display("test dual done");
   endtask

   task t_gross;
      put(8'h40, 16'h0000, 22'h030000, 1'b0);
      get(8'h40, 32'h6, 16'h0000, 6'h0, 32'h5);
      put(8'h41, 16'hffff, 22'h3c0000, 1'b0);
      get(8'h41, 32'h6, 16'hffff, 6'h0, 32'h5);
      $display("test gross done");
   endtask

   task t_data_bits;
      for (int i = 0; i < 16; i++) begin
         put(8'h10, 16'h3c96, 22'h1 << i, 1'b0);
         get(8'h10, 32'ha, 16'h3c96 ^ (16'h1 << i), ~col(i), 32'h3);
      end
      $display("test data bits done");
   endtask

   task t_check_bits;
      for (int j = 0; j < 6; j++) begin
         put(8'h20, 16'hc001, 22'h10000 << j, 1'b0);
         get(8'h20, 32'ha, 16'hc001, ~(6'h1 << j), 32'h3);
      end
      $display("test check bits done");
   endtask

   initial begin
      {psel, penable, pwrite, paddr, pwdata, err, i_nrst, last_err} = '0;
      errors = 0;
      checks_done = 0;
      repeat (16) @(posedge i_clk);
      i_nrst <= 1'b1;
      @(posedge i_clk);
      t_reset;
      t_clean;
      t_dual;
      t_gross;
      t_data_bits;
      t_check_bits;
      finish_test;
   end

   initial begin
      #200000;
      errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      finish_test;
   end
endmodule
